// ===== dcps_map.svh
`ifndef DCPS_MAP_SVH
`define DCPS_MAP_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define DCPS_OFS_CH1_CONTROL 8'hd0
`define DCPS_OFS_CH1_ALERT_EN 8'hd1
`define DCPS_OFS_CH1_STATUS 8'hd2
`define DCPS_OFS_CH2_CONTROL 8'hd4
`define DCPS_OFS_CH2_ALERT_EN 8'hd5
`define DCPS_OFS_CH2_STATUS 8'hd6
// Low two offset bits select the register inside a channel
`define DCPS_SUB_CONTROL 2'h0
`define DCPS_SUB_ALERT_EN 2'h1
`define DCPS_SUB_STATUS 2'h2

// -----------------------------------------------------------------
// Control register fields
// -----------------------------------------------------------------
`define DCPS_CTL_GPIO_MODE_HI 7
`define DCPS_CTL_GPIO_MODE_LO 6
`define DCPS_CTL_GPIO_OUT 5
`define DCPS_CTL_MASS_WR_EN 4
`define DCPS_CTL_FET_ON 3
`define DCPS_CTL_OC_RETRY 2
`define DCPS_CTL_UV_RETRY 1
`define DCPS_CTL_OV_RETRY 0

// -----------------------------------------------------------------
// Alert enable and status fields (same layout, bits 5..0)
// -----------------------------------------------------------------
`define DCPS_ALR_FET_SHORT 5
`define DCPS_ALR_EN_CHANGE 4
`define DCPS_ALR_POWER_BAD 3
`define DCPS_ALR_OVERCURRENT 2
`define DCPS_ALR_UNDERVOLT 1
`define DCPS_ALR_OVERVOLT 0
`define DCPS_ALR_USED_MASK 8'h3f
`define DCPS_STS_FET_ON 7
`define DCPS_STS_GPIO_LEVEL 6
`define DCPS_STS_FET_SHORT 5
`define DCPS_STS_ENABLED 4
`define DCPS_STS_POWER_BAD 3
`define DCPS_STS_OVERCURRENT 2
`define DCPS_STS_UNDERVOLT 1
`define DCPS_STS_OVERVOLT 0

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define DCPS_RST_CH1_CONTROL 8'h27
`define DCPS_RST_CH2_CONTROL 8'h37
`define DCPS_RST_ALERT_EN 8'h00

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define DCPS_ON_DEBOUNCE_CYC 16

`endif

// ===== dcps_pkg.sv
`default_nettype none

package dcps_pkg;

	// GPIO pin function selected by control bits 7:6
	typedef enum logic [1:0] {
		DCPS_GPIO_PGOOD = 2'b00,
		DCPS_GPIO_PBAD = 2'b01,
		DCPS_GPIO_OUTPUT = 2'b10,
		DCPS_GPIO_INPUT = 2'b11
	} dcps_gpio_mode_type;

	// Live sense levels of one channel, as they arrive at the pins
	typedef struct packed {
		logic fet_short;
		logic enable_n;
		logic power_feedback_input;
		logic overcurrent;
		logic undervoltage_sense_input;
		logic overvoltage_sense_input;
	} dcps_sense_type;

	// One register access, already decoded from the serial interface
	typedef struct packed {
		logic wr;
		logic rd;
		logic mass;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dcps_reg_req_type;

	// Per-channel settings handed to the analog side
	typedef struct packed {
		logic fet_on;
		logic oc_retry;
		logic uv_retry;
		logic ov_retry;
	} dcps_chan_ctl_type;

endpackage : dcps_pkg

`default_nettype wire

// ===== dcps_debounce.sv
`default_nettype none

`include "dcps_map.svh"

module dcps_debounce #(
	parameter int CYCLES = `DCPS_ON_DEBOUNCE_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Raw level and its settled view
	input wire logic i_level,
	output logic o_done,
	output logic o_level
);
	import dcps_pkg::*;

	localparam int CW = $clog2(CYCLES + 1);

	// A zero delay leaves the counter nothing to wait on
	if (CYCLES < 1) begin : g_bad_cycles
		$error("dcps_debounce: CYCLES must be at least 1");
	end

	logic [CW-1:0] cnt_q;
	logic last_q;
	logic armed_q;

	// -------------------------------------------------------------
	// Stability counter
	// -------------------------------------------------------------
	// Any edge restarts the delay, so a bouncing pin never captures
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			cnt_q <= '0;
			last_q <= 1'b0;
			armed_q <= 1'b0;
		end else if (i_level != last_q) begin
			last_q <= i_level;
			cnt_q <= '0;
			armed_q <= 1'b1;
		end else if (armed_q && cnt_q == CW'(CYCLES - 1)) begin
			armed_q <= 1'b0;
		end else if (armed_q) begin
			cnt_q <= cnt_q + CW'(1);
		end
	end

	// One-cycle pulse when the delay ends
	assign o_done = armed_q && (i_level == last_q) && cnt_q == CW'(CYCLES - 1);
	assign o_level = last_q;

endmodule : dcps_debounce

`default_nettype wire

// ===== dcps_regs.sv
// Functional notes
// - In output mode, control bit 5 high releases pin, low pulls low.
// - Channel two bit 4 enables mass-write response, default on; reserved ch1.
// - Control bit 3 drives the FET; it takes the debounced on-pin level.
// - Bit 2 set retries after overcurrent, clear latches off.
// - Bit 1 set retries after undervoltage, clear latches off.
// - Bit 0 set retries after overvoltage, clear latches off.
// - Alert bit 5 enables FET short alert; enables reset to zero.
// - Alert bit 4 enables alert on enable pin change.
// - Alert bit 3 enables alert on power bad.
// - Alert bit 2 enables alert on overcurrent.
// - Alert bit 1 enables alert on input undervoltage.
// - Alert bit 0 enables alert on input overvoltage.
// - Status bit 7 shows FET switched on.
// - Status bit 6 shows present GPIO pin level.
// - Status bit 5 shows present FET short.
// - Status bit 4 is one while enable pin is low.
// - Status bit 3 is one while feedback input is low.
// - Status bit 2 is one while overcurrent exists.
// - Status bit 1 is one while undervoltage input is low.
// - Status bit 0 is one while overvoltage input is high.
// - Alert pulls low only when a fault log bit sets with enable set.
// - Continuing faults raise no new alert until the log bit clears.
`default_nettype none

`include "dcps_map.svh"

module dcps_regs #(
	parameter int NCH = 2,
	parameter int ON_DEBOUNCE = `DCPS_ON_DEBOUNCE_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Register access from the serial interface
	input wire dcps_pkg::dcps_reg_req_type i_req,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	output logic o_mass_write_en,
	// Channel pins and analog side
	input wire dcps_pkg::dcps_sense_type [NCH-1:0] i_sense,
	input wire logic [NCH-1:0] i_on_pin,
	input wire logic [NCH-1:0] i_fault_event,
	output dcps_pkg::dcps_chan_ctl_type [NCH-1:0] o_chan_ctl,
	// General pins (open drain)
	input wire logic [NCH-1:0] i_general_pin,
	output logic [NCH-1:0] o_general_pin,
	output logic [NCH-1:0] o_general_pin_oe,
	// Fault log bits and alert line
	input wire logic [NCH-1:0][5:0] i_fault_log,
	input wire logic i_alert_release,
	output logic o_alert,
	output logic o_alert_oe
);
	import dcps_pkg::*;

	// -------------------------------------------------------------
	// Elaboration checks
	// -------------------------------------------------------------
	// The offset decode only knows two channels
	if (NCH != 2) begin : g_bad_nch
		$error("dcps_regs: register map serves exactly two channels");
	end
	// A zero delay would capture every glitch of the on pin
	if (ON_DEBOUNCE < 1) begin : g_bad_debounce
		$error("dcps_regs: ON_DEBOUNCE must be at least 1");
	end

	// -------------------------------------------------------------
	// Decoding helpers
	// -------------------------------------------------------------
	// Channel select from an offset; -1 when outside the bank
	function automatic int chan_of(input logic [7:0] addr);
		if (addr[7:3] == 5'(`DCPS_OFS_CH1_CONTROL >> 3)
			&& addr[1:0] != 2'h3) begin
			return int'(addr[2]);
		end
		return -1;
	endfunction : chan_of

	// True when a request hits one register of one channel
	function automatic logic hits(input dcps_reg_req_type req,
		input int ch, input logic [1:0] sub);
		return chan_of(req.addr) == ch && req.addr[1:0] == sub;
	endfunction : hits

	// Write mask per channel: reserved bits never store
	function automatic logic [7:0] ctl_mask(input int ch);
		return (ch == 1) ? 8'hff : 8'hef;
	endfunction : ctl_mask

	// -------------------------------------------------------------
	// Register state
	// -------------------------------------------------------------
	logic [NCH-1:0][7:0] ctl_q;
	logic [NCH-1:0][7:0] alr_q;
	logic [NCH-1:0][7:0] sts;
	logic [NCH-1:0][5:0] log_q;
	logic [NCH-1:0] alert_req;
	logic [NCH-1:0] on_done;
	logic [NCH-1:0] on_level;
	logic alert_q;
	logic [7:0] rdata_q;
	logic rvalid_q;

	// Mass-write writes are only taken when channel two allows them
	logic wr_ok;
	assign wr_ok = i_req.wr
		&& (!i_req.mass || ctl_q[1][`DCPS_CTL_MASS_WR_EN]);

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			dcps_gpio_mode_type mode;
			logic fet_clr;
			logic pin_low;

			// -----------------------------------------------------
			// On-pin debounce
			// -----------------------------------------------------
			dcps_debounce #(
				.CYCLES(ON_DEBOUNCE)
			) u_on_db (
				.i_clk(i_clk),
				.i_rstn(i_rstn),
				.i_level(i_on_pin[g]),
				.o_done(on_done[g]),
				.o_level(on_level[g])
			);

			// -----------------------------------------------------
			// Latch-off decision
			// -----------------------------------------------------
			// A fault with its retry bit clear drops the FET bit and
			// keeps it dropped until software or a debounced on-pin capture sets it again
			always_comb begin
				fet_clr = 1'b0;
				if (i_fault_event[g]) begin
					if (i_sense[g].overcurrent
						&& !ctl_q[g][`DCPS_CTL_OC_RETRY]) begin
						fet_clr = 1'b1;
					end
					if (!i_sense[g].undervoltage_sense_input
						&& !ctl_q[g][`DCPS_CTL_UV_RETRY]) begin
						fet_clr = 1'b1;
					end
					if (i_sense[g].overvoltage_sense_input
						&& !ctl_q[g][`DCPS_CTL_OV_RETRY]) begin
						fet_clr = 1'b1;
					end
				end
			end

			// -----------------------------------------------------
			// Control register
			// -----------------------------------------------------
			// Hardware latch-off wins over a write in the same cycle;
			// a debounced on-pin capture wins over software
			always_ff @(posedge i_clk) begin
				if (!i_rstn) begin
					ctl_q[g] <= (g == 1) ? `DCPS_RST_CH2_CONTROL
						: `DCPS_RST_CH1_CONTROL;
				end else begin
					if (wr_ok && hits(i_req, g, `DCPS_SUB_CONTROL)) begin
						ctl_q[g] <= i_req.wdata & ctl_mask(g);
					end
					if (on_done[g]) begin
						ctl_q[g][`DCPS_CTL_FET_ON] <= on_level[g];
					end
					if (fet_clr) begin
						ctl_q[g][`DCPS_CTL_FET_ON] <= 1'b0;
					end
				end
			end

			// -----------------------------------------------------
			// Alert enable register
			// -----------------------------------------------------
			// Bits 7:6 are unused and never store
			always_ff @(posedge i_clk) begin
				if (!i_rstn) begin
					alr_q[g] <= `DCPS_RST_ALERT_EN;
				end else if (wr_ok && hits(i_req, g, `DCPS_SUB_ALERT_EN)) begin
					alr_q[g] <= i_req.wdata & `DCPS_ALR_USED_MASK;
				end
			end

			// -----------------------------------------------------
			// Settings to the analog side
			// -----------------------------------------------------
			assign o_chan_ctl[g].fet_on = ctl_q[g][`DCPS_CTL_FET_ON];
			assign o_chan_ctl[g].oc_retry = ctl_q[g][`DCPS_CTL_OC_RETRY];
			assign o_chan_ctl[g].uv_retry = ctl_q[g][`DCPS_CTL_UV_RETRY];
			assign o_chan_ctl[g].ov_retry = ctl_q[g][`DCPS_CTL_OV_RETRY];

			// -----------------------------------------------------
			// General pin driver
			// -----------------------------------------------------
			// Open drain: the pin can only be pulled low or released
			assign mode = dcps_gpio_mode_type'(
				ctl_q[g][`DCPS_CTL_GPIO_MODE_HI:`DCPS_CTL_GPIO_MODE_LO]);
			always_comb begin
				unique case (mode)
					DCPS_GPIO_PGOOD: begin
						pin_low = !i_sense[g].power_feedback_input;
					end
					DCPS_GPIO_PBAD: begin
						pin_low = i_sense[g].power_feedback_input;
					end
					DCPS_GPIO_OUTPUT: begin
						pin_low = !ctl_q[g][`DCPS_CTL_GPIO_OUT];
					end
					DCPS_GPIO_INPUT: begin
						pin_low = 1'b0;
					end
				endcase
			end
			assign o_general_pin[g] = 1'b0;
			assign o_general_pin_oe[g] = pin_low;

			// -----------------------------------------------------
			// Live status
			// -----------------------------------------------------
			always_comb begin
				sts[g] = '0;
				sts[g][`DCPS_STS_FET_ON] = ctl_q[g][`DCPS_CTL_FET_ON];
				sts[g][`DCPS_STS_GPIO_LEVEL] = i_general_pin[g];
				sts[g][`DCPS_STS_FET_SHORT] = i_sense[g].fet_short;
				sts[g][`DCPS_STS_ENABLED] = !i_sense[g].enable_n;
				sts[g][`DCPS_STS_POWER_BAD] =
					!i_sense[g].power_feedback_input;
				sts[g][`DCPS_STS_OVERCURRENT] = i_sense[g].overcurrent;
				sts[g][`DCPS_STS_UNDERVOLT] =
					!i_sense[g].undervoltage_sense_input;
				sts[g][`DCPS_STS_OVERVOLT] =
					i_sense[g].overvoltage_sense_input;
			end

			// -----------------------------------------------------
			// Fault log edge tracking
			// -----------------------------------------------------
			// Only a 0 to 1 step of a log bit counts, so a bit that
			// stays set raises nothing until it is cleared first
			always_ff @(posedge i_clk) begin
				if (!i_rstn) begin
					log_q[g] <= '0;
				end else begin
					log_q[g] <= i_fault_log[g];
				end
			end
			assign alert_req[g] =
				|(i_fault_log[g] & ~log_q[g] & alr_q[g][5:0]);
		end
	endgenerate

	// -------------------------------------------------------------
	// Alert line
	// -------------------------------------------------------------
	// A new request in the release cycle wins, so it is not lost
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			alert_q <= 1'b0;
		end else if (|alert_req) begin
			alert_q <= 1'b1;
		end else if (i_alert_release) begin
			alert_q <= 1'b0;
		end
	end
	assign o_alert = 1'b0;
	assign o_alert_oe = alert_q;

	// -------------------------------------------------------------
	// Read path
	// -------------------------------------------------------------
	// Unmapped offsets read as zero; data is held until next read
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= i_req.rd;
			if (i_req.rd) begin
				rdata_q <= 8'h00;
				for (int c = 0; c < NCH; c++) begin
					if (hits(i_req, c, `DCPS_SUB_CONTROL)) begin
						rdata_q <= ctl_q[c];
					end
					if (hits(i_req, c, `DCPS_SUB_ALERT_EN)) begin
						rdata_q <= alr_q[c];
					end
					if (hits(i_req, c, `DCPS_SUB_STATUS)) begin
						rdata_q <= sts[c];
					end
				end
			end
		end
	end
	assign o_rdata = rdata_q;
	assign o_rvalid = rvalid_q;
	assign o_mass_write_en = ctl_q[1][`DCPS_CTL_MASS_WR_EN];

endmodule : dcps_regs

`default_nettype wire

// ===== dcps_regs_sva.sv
`default_nettype none

module dcps_regs_sva #(
	parameter int NCH = 2
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire dcps_pkg::dcps_reg_req_type i_req,
	input wire logic [7:0] o_rdata,
	input wire logic o_rvalid,
	input wire logic o_mass_write_en,
	input wire dcps_pkg::dcps_sense_type [NCH-1:0] i_sense,
	input wire logic [NCH-1:0] i_fault_event,
	input wire dcps_pkg::dcps_chan_ctl_type [NCH-1:0] o_chan_ctl,
	input wire logic [NCH-1:0] i_general_pin,
	input wire logic [NCH-1:0] o_general_pin_oe,
	input wire logic [NCH-1:0][5:0] i_fault_log,
	input wire logic i_alert_release,
	input wire logic o_alert_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	import dcps_pkg::*;
	logic [NCH-1:0][5:0] log_q;
	logic rise;
	logic [7:0] sts0;
	// -----------------------------------------------------------------
	// Helper logic
	// -----------------------------------------------------------------
	// Log history, cleared like the design's so a set bit counts at release
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			log_q <= '0;
		end else begin
			log_q <= i_fault_log;
		end
	end
	// Any new log bit, and the live status of channel one
	assign rise = |(i_fault_log & ~log_q);
	assign sts0 = {o_chan_ctl[0].fet_on, i_general_pin[0],
		i_sense[0].fet_short, !i_sense[0].enable_n,
		!i_sense[0].power_feedback_input, i_sense[0].overcurrent,
		!i_sense[0].undervoltage_sense_input,
		i_sense[0].overvoltage_sense_input};
	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);
	sequence s_read;
		i_req.rd;
	endsequence
	sequence s_no_new_fault;
		!rise;
	endsequence
	a_read_answer: assert property (s_read |=> o_rvalid)
		else $error("read got no answer");
	a_answer_cause: assert property (o_rvalid |-> $past(i_req.rd))
		else $error("answer without read");
	a_status_data: assert property (
		s_read ##0 (i_req.addr == 8'hd2) |=> o_rdata == $past(sts0))
		else $error("status byte wrong");
	a_reset_ctl: assert property (disable iff (1'b0)
		!i_rstn |=> o_chan_ctl[0] == 4'h7 && o_mass_write_en)
		else $error("control reset value wrong");
	a_gpio_reset: assert property (disable iff (1'b0)
		!i_rstn ##1 !i_rstn |-> o_general_pin_oe[0] ==
		!i_sense[0].power_feedback_input)
		else $error("pin not power good at reset");
	a_oc_latch: assert property (i_fault_event[0] &&
		i_sense[0].overcurrent && !o_chan_ctl[0].oc_retry
		|=> !o_chan_ctl[0].fet_on) else $error("no overcurrent latch");
	a_uv_latch: assert property (i_fault_event[0] &&
		!i_sense[0].undervoltage_sense_input && !o_chan_ctl[0].uv_retry
		|=> !o_chan_ctl[0].fet_on) else $error("no undervoltage latch");
	a_ov_latch: assert property (i_fault_event[0] &&
		i_sense[0].overvoltage_sense_input && !o_chan_ctl[0].ov_retry
		|=> !o_chan_ctl[0].fet_on) else $error("no overvoltage latch");
	a_alert_quiet: assert property (!o_alert_oe ##0
		s_no_new_fault |=> !o_alert_oe) else $error("alert without new fault");
	a_alert_release: assert property (i_alert_release ##0
		s_no_new_fault |=> !o_alert_oe) else $error("alert not released");
	a_alert_hold: assert property (o_alert_oe &&
		!i_alert_release |=> o_alert_oe) else $error("alert dropped early");
endmodule : dcps_regs_sva

bind dcps_regs dcps_regs_sva #(.NCH(NCH)) i_dcps_regs_sva (
	.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .o_rdata(o_rdata),
	.o_rvalid(o_rvalid), .o_mass_write_en(o_mass_write_en),
	.i_sense(i_sense), .i_fault_event(i_fault_event),
	.o_chan_ctl(o_chan_ctl), .i_general_pin(i_general_pin),
	.o_general_pin_oe(o_general_pin_oe), .i_fault_log(i_fault_log),
	.i_alert_release(i_alert_release), .o_alert_oe(o_alert_oe));

`default_nettype wire

// ===== dcps_host_model.sv
`default_nettype none

module dcps_host_model (
	// Clock
	input wire logic i_clk,
	// Register port of the bank
	output dcps_pkg::dcps_reg_req_type o_req,
	input wire logic [7:0] i_rdata,
	input wire logic i_rvalid,
	// Open-drain general pins with pull-ups
	input wire logic [1:0] i_pin_oe,
	input wire logic [1:0] i_ext_low,
	output logic [1:0] o_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	import dcps_pkg::*;
	// Pull-up wins unless some party sinks the line
	assign o_pin = ~(i_pin_oe | i_ext_low);
	initial o_req = '0;
	// One byte access; idle address and data are inverted, not held
	task automatic access(input logic w, input logic m, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge i_clk);
		o_req = '{w, !w, m, a, d};
		@(negedge i_clk);
		q = (w || i_rvalid === 1'b1) ? i_rdata : 8'hxx;
		o_req = '{1'b0, 1'b0, 1'b0, ~a, ~d};
	endtask : access
endmodule : dcps_host_model

`default_nettype wire

// ===== dcps_regs_bench.sv
`default_nettype none

module dcps_regs_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import dcps_pkg::*;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	dcps_reg_req_type req;
	logic [7:0] rdata, q, w;
	logic rvalid, mass_en, alert_oe, rel, al_drv;
	dcps_sense_type [1:0] sense;
	logic [1:0] on_pin, fevent, pin, pin_oe, ext_low, gp_drv;
	dcps_chan_ctl_type [1:0] ctl;
	logic [1:0][5:0] flog;
	logic [31:0] lfsr = 32'hca911639;
	logic [7:0] ra [5] = '{8'hd0, 8'hd4, 8'hd1, 8'hd5, 8'hd3};
	logic [7:0] rv [5] = '{8'h27, 8'h37, 8'h00, 8'h00, 8'h00};
	logic [7:0] wa [4] = '{8'hd0, 8'hd1, 8'hd4, 8'hd5};
	logic [7:0] wm [4] = '{8'hef, 8'h3f, 8'hff, 8'h3f};
	int fail_count = 0;
	int n_checks = 0;
	// Short debounce keeps the run brief
	dcps_regs #(.NCH(2), .ON_DEBOUNCE(2)) i_dcps_regs (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_req(req), .o_rdata(rdata),
		.o_rvalid(rvalid), .o_mass_write_en(mass_en), .i_sense(sense),
		.i_on_pin(on_pin), .i_fault_event(fevent), .o_chan_ctl(ctl),
		.i_general_pin(pin), .o_general_pin(gp_drv),
		.o_general_pin_oe(pin_oe), .i_fault_log(flog),
		.i_alert_release(rel), .o_alert(al_drv), .o_alert_oe(alert_oe));
	dcps_host_model i_dcps_host_model (.i_clk(i_clk), .o_req(req),
		.i_rdata(rdata), .i_rvalid(rvalid), .i_pin_oe(pin_oe),
		.i_ext_low(ext_low), .o_pin(pin));
	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	always #50 i_clk = ~i_clk;
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
	endfunction : nxt
	// Expected status in power good mode, where the pin follows feedback
	function automatic logic [7:0] exp_sts(input dcps_sense_type s,
		input logic f);
		return {f, s.power_feedback_input, s.fet_short, !s.enable_n,
			!s.power_feedback_input, s.overcurrent,
			!s.undervoltage_sense_input, s.overvoltage_sense_input};
	endfunction : exp_sts
	// Pull enable from {mode, output bit, feedback}
	function automatic logic exp_oe(input logic [3:0] v);
		case (v[3:2])
			2'h0: return !v[0];
			2'h1: return v[0];
			2'h2: return !v[1];
			default: return 1'b0;
		endcase
	endfunction : exp_oe
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic m);
		i_dcps_host_model.access(1'b1, m, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		i_dcps_host_model.access(1'b0, 1'b0, a, 8'h00, q);
	endtask : rd
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	initial begin
		{sense, on_pin, fevent, flog, rel, ext_low} = '0;
		repeat (4) @(negedge i_clk);
		i_rstn = 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd(ra[i]);
			chk(q, rv[i]);
		end
		chk({7'h0, mass_en}, 8'h01);
		// Random pins; status writes must be ignored
		for (int i = 0; i < 8; i++) begin
			lfsr = nxt(lfsr);
			sense = lfsr[11:0];
			wr(i[0] ? 8'hd6 : 8'hd2, 8'hff, 1'b0);
			rd(i[0] ? 8'hd6 : 8'hd2);
			chk(q, exp_sts(sense[i%2], 1'b0));
		end
		for (int i = 0; i < 4; i++) begin
			lfsr = nxt(lfsr);
			w = lfsr[7:0];
			wr(wa[i], w, 1'b0);
			rd(wa[i]);
			chk(q, w & wm[i]);
		end
		wr(8'hd4, 8'h37, 1'b0);
		// Every pin function, output level and feedback level
		for (int i = 0; i < 16; i++) begin
			sense[0].power_feedback_input = i[0];
			ext_low[0] = i[2];
			wr(8'hd0, {i[3:1], 5'h07}, 1'b0);
			chk({7'h0, pin_oe[0]}, {7'h0, exp_oe(i[3:0])});
			rd(8'hd2);
			chk({7'h0, q[6]}, {7'h0, !(exp_oe(i[3:0]) | i[2])});
		end
		ext_low = '0;
		// Open-drain pins may only ever drive low
		chk({5'h0, al_drv, gp_drv}, 8'h00);
		// Mass write honoured, then refused once disabled
		wr(8'hd1, 8'h2a, 1'b1);
		wr(8'hd4, 8'h27, 1'b0);
		wr(8'hd1, 8'h15, 1'b1);
		rd(8'hd1);
		chk(q, 8'h2a);
		chk({7'h0, mass_en}, 8'h00);
		wr(8'hd4, 8'h37, 1'b0);
		on_pin[0] = 1'b1;
		repeat (4) @(negedge i_clk);
		chk({4'h0, ctl[0]}, 8'h0f);
		// Each fault kind, latched off and then retried
		for (int k = 0; k < 6; k++) begin
			wr(8'hd0, {5'h05, (k > 2) ? 3'h7 : ~(3'h1 << (k % 3))}, 1'b0);
			sense[0] = {3'h1, k % 3 == 2, k % 3 != 1, k % 3 == 0};
			fevent[0] = 1'b1;
			@(negedge i_clk);
			fevent[0] = 1'b0;
			rd(8'hd2);
			chk({7'h0, q[7]}, {7'h0, k > 2});
		end
		// Each alert source: masked, raised, released, no repeat
		for (int b = 0; b < 6; b++) begin
			wr(b[0] ? 8'hd5 : 8'hd1, 8'h01 << b, 1'b0);
			flog[b%2] = 6'h01 << ((b + 1) % 6);
			repeat (3) @(negedge i_clk);
			chk({7'h0, alert_oe}, 8'h00);
			flog[b%2] = flog[b%2] | (6'h01 << b);
			repeat (2) @(negedge i_clk);
			chk({7'h0, alert_oe}, 8'h01);
			rel = 1'b1;
			@(negedge i_clk);
			rel = 1'b0;
			repeat (3) @(negedge i_clk);
			chk({7'h0, alert_oe}, 8'h00);
			// Cleared and then raised again alerts anew
			flog[b%2] = '0;
			@(negedge i_clk);
			flog[b%2] = 6'h01 << b;
			repeat (2) @(negedge i_clk);
			chk({7'h0, alert_oe}, 8'h01);
			rel = 1'b1;
			@(negedge i_clk);
			rel = 1'b0;
			flog = '0;
		end
		results();
	end
	// Watchdog far beyond the few hundred cycles the scenarios need
	initial begin
		#2000000;
		fail_count++;
		results();
	end
endmodule : dcps_regs_bench

`default_nettype wire
